//--- scp_regs.vh
// Purpose: Constants for the serial configuration slave port
// Assumes: Included by bare name from every design file of the port except the synchroniser
// Notes:   Definitions only; reset values of flops live beside them
//
// Functional notes
// RULE1 - The board straps the interface select to 01 for two-wire or 10 for SPI before reset ends.
// RULE2 - In two-wire mode the port answers only address byte 1011_1111 for read and 1011_1110 for write.
// RULE3 - Two-wire transfers follow small serial EEPROM framing: address byte, register byte, data bytes.
// RULE4 - Every configuration register is reachable for read and write through the selected port.
// RULE5 - Tables and counters are reached only through the indirect window of registers 121 to 131.
// RULE6 - SPI command 0000_0011 reads, 0000_0010 writes, and any other command is ignored.
// RULE7 - An SPI frame is command byte, register address byte, then data bytes, all MSB first.
// RULE8 - While select stays low after a read byte, the address steps and the next register shifts out.
// RULE9 - While select stays low after a written byte, the address steps and the next byte lands there.
// RULE10 - A burst ends only when select goes high, and the port then drops the burst.
// RULE11 - In bursts the address wraps from the highest register back to zero.
// RULE12 - The master keeps the serial clock at or below 25 MHz and keeps bytes flowing.
// RULE13 - Read data leaves on the falling serial clock edge and input is taken on the rising edge.
// RULE14 - The master resets, writes its settings, then reads them back before relying on them.
// RULE15 - Writes reach the switch core at once, so live settings change without a restart.
`ifndef SCP_REGS_VH
`define SCP_REGS_VH

// ----------------------------------------
// Strap codes and command bytes
// ----------------------------------------
`define SCP_SEL_I2C      2'h1
`define SCP_SEL_SPI      2'h2
`define SCP_SPI_CMD_RD   8'h03
`define SCP_SPI_CMD_WR   8'h02
`define SCP_I2C_DEV_RD   8'hbf
`define SCP_I2C_DEV_WR   8'hbe

// ----------------------------------------
// Register space
// ----------------------------------------
`define SCP_REG_LAST     8'hc6
`define SCP_WIN_FIRST    8'h79
`define SCP_WIN_LAST     8'h83

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCP_STRAP_SETTLE 2'h3
`define SCP_SYS_CLK_MHZ  100
`define SCP_SCK_MAX_MHZ  25
`define SCP_SCK_MIN_CYC  (`SCP_SYS_CLK_MHZ / `SCP_SCK_MAX_MHZ)

`endif

//--- scp_sync.v
// Purpose: Two-flop synchroniser for a group of pin levels
// Assumes: Inputs are asynchronous levels, not pulses
// Notes:   First stage is read by the second stage only
`timescale 1ns/1ps
module scp_sync #(
  parameter       W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input  wire         sys_clk_i,
  input  wire         reset_i,
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);
  reg [W-1:0] meta_q;

  // Two stages; metastability settles in the first
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // scp_sync

//--- scp_addr_ctr.v
// Purpose: Register address counter with load, step and wrap
// Assumes: Load and step never come in the same cycle
// Notes:   Shared by both slave modes, only one runs at a time
`timescale 1ns/1ps
`include "scp_regs.vh"
module scp_addr_ctr #(
  parameter [7:0] LAST = `SCP_REG_LAST
) (
  input  wire       sys_clk_i,
  input  wire       reset_i,
  input  wire       load_i,
  input  wire [7:0] load_val_i,
  input  wire       step_i,
  output reg  [7:0] addr_o
);
  // Step wraps at the top; a start above the top also wraps
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      addr_o <= 8'h00;
    else if (load_i)
      addr_o <= load_val_i;
    else if (step_i)
      addr_o <= (addr_o >= LAST) ? 8'h00 : addr_o + 8'h01; // see RULE11
  end
endmodule // scp_addr_ctr

//--- scp_port.v
// Purpose: Host configuration port, SPI or two-wire slave by strap
// Assumes: Core decodes reg_addr_o and returns reg_rdata_i in the
//          same cycle as reg_rd_o; writes act in the reg_wr_o cycle
// Notes:   Pins are oversampled by sys_clk_i; serial clock must stay
//          at or below a sixth of sys_clk_i for reads to keep pace
`timescale 1ns/1ps
`include "scp_regs.vh"
module scp_port #(
  parameter [7:0] REG_LAST = `SCP_REG_LAST
) (
  input  wire       sys_clk_i,
  input  wire       reset_i,
  input  wire [1:0] interface_select_straps_i,
  input  wire       host_select_n_i,
  input  wire       host_serial_clock_i,
  input  wire       host_data_in_i,
  output reg        host_data_in_o,
  output reg        host_data_in_oe_o,
  output reg        host_data_out_o,
  output reg        host_data_out_oe_o,
  output wire [7:0] reg_addr_o,
  output reg  [7:0] reg_wdata_o,
  output reg        reg_wr_o,
  output reg        reg_rd_o,
  input  wire [7:0] reg_rdata_i,
  output reg        reg_window_o,
  output reg        spi_mode_o,
  output reg        i2c_mode_o
);

  // ----------------------------------------
  // Local codes
  // ----------------------------------------
  localparam [1:0] SP_CMD  = 2'h0;
  localparam [1:0] SP_ADDR = 2'h1;
  localparam [1:0] SP_DATA = 2'h2;
  localparam [1:0] SP_IGN  = 2'h3;

  localparam [2:0] IC_IDLE  = 3'h0;
  localparam [2:0] IC_DEV   = 3'h1;
  localparam [2:0] IC_ADDR  = 3'h2;
  localparam [2:0] IC_WDATA = 3'h3;
  localparam [2:0] IC_RDATA = 3'h4;

  // Address falls in the indirect table window
  function in_window;
    input [7:0] a;
    begin
      in_window = (a >= `SCP_WIN_FIRST) && (a <= `SCP_WIN_LAST);
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------
  wire [4:0] pins_s;
  wire [1:0] straps_s = pins_s[4:3];
  wire       sel_n_s  = pins_s[2];
  wire       sck_s    = pins_s[1];
  wire       sdi_s    = pins_s[0];

  // Select idles high so a floating start does not open a frame
  scp_sync #(
    .W       (5),
    .RST_VAL (5'h04)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   ({interface_select_straps_i, host_select_n_i,
                 host_serial_clock_i, host_data_in_i}),
    .sync_o    (pins_s)
  );

  reg sck_d_q;
  reg sdi_d_q;

  // Third stage for edge detection, fed only by settled levels
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sck_d_q <= 1'b0;
      sdi_d_q <= 1'b1;
    end
    else
    begin
      sck_d_q <= sck_s;
      sdi_d_q <= sdi_s;
    end
  end

  wire sck_rise = sck_s & ~sck_d_q;
  wire sck_fall = ~sck_s & sck_d_q;

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  reg [1:0] settle_q;

  // Straps are read once, after the synchroniser has filled
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      settle_q   <= 2'h0;
      spi_mode_o <= 1'b0;
      i2c_mode_o <= 1'b0;
    end
    else if (settle_q != `SCP_STRAP_SETTLE)
    begin
      settle_q <= settle_q + 2'h1;
      if (settle_q == `SCP_STRAP_SETTLE - 2'h1)
      begin
        spi_mode_o <= (straps_s == `SCP_SEL_SPI); // see RULE1
        i2c_mode_o <= (straps_s == `SCP_SEL_I2C); // see RULE1
      end
    end
  end

  // ----------------------------------------
  // Shared address counter and read data
  // ----------------------------------------
  reg        spi_ld_q;
  reg        spi_inc_q;
  reg        spi_rd_q;
  reg        spi_wr_q;
  reg  [7:0] spi_sh_q;
  reg        i2c_ld_q;
  reg        i2c_inc_q;
  reg        i2c_rd_q;
  reg        i2c_wr_q;
  reg  [7:0] i2c_sh_q;
  reg  [7:0] tx_q;
  wire       tx_shift;

  wire [7:0] byte_val = spi_mode_o ? spi_sh_q : i2c_sh_q;

  // Written register steps only after its write cycle is over
  scp_addr_ctr #(
    .LAST (REG_LAST)
  ) u_addr (
    .sys_clk_i  (sys_clk_i),
    .reset_i    (reset_i),
    .load_i     (spi_ld_q | i2c_ld_q),
    .load_val_i (byte_val),
    .step_i     (spi_inc_q | i2c_inc_q | reg_wr_o), // see RULE9
    .addr_o     (reg_addr_o)
  );

  // Core strobes; any address up to the top is reachable
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reg_rd_o     <= 1'b0;
      reg_wr_o     <= 1'b0;
      reg_wdata_o  <= 8'h00;
      reg_window_o <= 1'b0;
    end
    else
    begin
      reg_rd_o     <= spi_rd_q | i2c_rd_q; // see RULE4
      reg_wr_o     <= spi_wr_q | i2c_wr_q; // see RULE15
      reg_window_o <= in_window(reg_addr_o); // see RULE5
      if (spi_wr_q | i2c_wr_q)
        reg_wdata_o <= byte_val;
    end
  end

  // Read byte is caught in the strobe cycle, then shifted MSB first
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      tx_q <= 8'h00;
    else if (reg_rd_o)
      tx_q <= reg_rdata_i;
    else if (tx_shift)
      tx_q <= {tx_q[6:0], 1'b0};
  end

  // ----------------------------------------
  // SPI slave
  // ----------------------------------------
  reg [1:0] spi_st_q;
  reg [2:0] spi_bit_q;
  reg       spi_read_q;

  wire spi_act    = spi_mode_o & ~sel_n_s;
  wire [7:0] spi_byte = {spi_sh_q[6:0], sdi_s};
  wire spi_done   = spi_act & sck_rise & (spi_bit_q == 3'h7);
  wire spi_shift  = spi_act & sck_fall & (spi_st_q == SP_DATA)
                    & spi_read_q;

  assign tx_shift = spi_shift | i2c_shift;

  // Select high drops any frame at once, whatever its phase
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      spi_st_q   <= SP_CMD;
      spi_bit_q  <= 3'h0;
      spi_read_q <= 1'b0;
      spi_sh_q   <= 8'h00;
      spi_ld_q   <= 1'b0;
      spi_inc_q  <= 1'b0;
      spi_rd_q   <= 1'b0;
      spi_wr_q   <= 1'b0;
    end
    else
    begin
      spi_ld_q  <= 1'b0;
      spi_inc_q <= 1'b0;
      spi_rd_q  <= 1'b0;
      spi_wr_q  <= 1'b0;
      if (!spi_act)
      begin
        spi_st_q  <= SP_CMD; // see RULE10
        spi_bit_q <= 3'h0;
      end
      else if (sck_rise)
      begin
        spi_sh_q  <= spi_byte; // see RULE13
        spi_bit_q <= spi_bit_q + 3'h1; // see RULE7
      end
      if (spi_done)
      begin
        case (spi_st_q)
          SP_CMD:
          begin
            spi_read_q <= (spi_byte == `SCP_SPI_CMD_RD);
            if (spi_byte == `SCP_SPI_CMD_RD ||
                spi_byte == `SCP_SPI_CMD_WR)
              spi_st_q <= SP_ADDR; // see RULE6
            else
              spi_st_q <= SP_IGN; // see RULE6
          end
          SP_ADDR:
          begin
            spi_ld_q <= 1'b1; // see RULE7
            spi_rd_q <= spi_read_q;
            spi_st_q <= SP_DATA;
          end
          SP_DATA:
          begin
            spi_inc_q <= spi_read_q; // see RULE8
            spi_rd_q  <= spi_read_q; // see RULE8
            spi_wr_q  <= ~spi_read_q; // see RULE9
          end
          default:
            spi_st_q <= SP_IGN;
        endcase
      end
    end
  end

  // Output drives only while selected; data moves on falling clock
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      host_data_out_o    <= 1'b0;
      host_data_out_oe_o <= 1'b0;
    end
    else
    begin
      host_data_out_oe_o <= spi_act;
      if (!spi_act)
        host_data_out_o <= 1'b0;
      else if (spi_shift)
        host_data_out_o <= tx_q[7]; // see RULE13
    end
  end

  // ----------------------------------------
  // Two-wire slave
  // ----------------------------------------
  reg [2:0] i2c_st_q;
  reg [3:0] i2c_cnt_q;
  reg       i2c_ack_q;

  wire i2c_start = i2c_mode_o & sck_s & sdi_d_q & ~sdi_s;
  wire i2c_stop  = i2c_mode_o & sck_s & ~sdi_d_q & sdi_s;
  wire i2c_edge  = i2c_mode_o & ~i2c_start & ~i2c_stop;
  wire i2c_rx    = (i2c_st_q == IC_DEV) | (i2c_st_q == IC_ADDR)
                   | (i2c_st_q == IC_WDATA);
  wire i2c_shift = i2c_edge & sck_fall & (i2c_st_q == IC_RDATA)
                   & (i2c_ack_q | (i2c_cnt_q < 4'h8));

  // Bits taken on clock rise; acknowledge and read bits set on fall
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      i2c_st_q          <= IC_IDLE;
      i2c_cnt_q         <= 4'h0;
      i2c_ack_q         <= 1'b0;
      i2c_sh_q          <= 8'h00;
      i2c_ld_q          <= 1'b0;
      i2c_inc_q         <= 1'b0;
      i2c_rd_q          <= 1'b0;
      i2c_wr_q          <= 1'b0;
      host_data_in_oe_o <= 1'b0;
    end
    else
    begin
      i2c_ld_q  <= 1'b0;
      i2c_inc_q <= 1'b0;
      i2c_rd_q  <= 1'b0;
      i2c_wr_q  <= 1'b0;
      if (!i2c_mode_o || i2c_stop)
      begin
        i2c_st_q          <= IC_IDLE;
        i2c_ack_q         <= 1'b0;
        host_data_in_oe_o <= 1'b0;
      end
      else if (i2c_start)
      begin
        i2c_st_q          <= IC_DEV; // see RULE3
        i2c_cnt_q         <= 4'h0;
        i2c_ack_q         <= 1'b0;
        host_data_in_oe_o <= 1'b0;
      end
      else if (sck_rise)
      begin
        // Ninth clock belongs to the acknowledge, not to the next byte
        if (i2c_rx && !i2c_ack_q && i2c_cnt_q < 4'h8)
        begin
          i2c_sh_q  <= {i2c_sh_q[6:0], sdi_s};
          i2c_cnt_q <= i2c_cnt_q + 4'h1;
        end
        else if (i2c_st_q == IC_RDATA && i2c_cnt_q == 4'h9)
        begin
          // Master acknowledge asks for the next register
          i2c_cnt_q <= 4'h0;
          if (!sdi_s)
          begin
            i2c_inc_q <= 1'b1; // see RULE3
            i2c_rd_q  <= 1'b1;
          end
          else
            i2c_st_q <= IC_IDLE;
        end
      end
      else if (sck_fall)
      begin
        if (i2c_ack_q)
        begin
          i2c_ack_q         <= 1'b0;
          host_data_in_oe_o <= 1'b0;
          if (i2c_st_q == IC_RDATA)
          begin
            host_data_in_oe_o <= ~tx_q[7];
            i2c_cnt_q         <= 4'h1;
          end
        end
        else if (i2c_rx && i2c_cnt_q == 4'h8)
        begin
          i2c_cnt_q         <= 4'h0;
          i2c_ack_q         <= 1'b1;
          host_data_in_oe_o <= 1'b1;
          case (i2c_st_q)
            IC_DEV:
            begin
              if (i2c_sh_q == `SCP_I2C_DEV_WR)
                i2c_st_q <= IC_ADDR; // see RULE2
              else if (i2c_sh_q == `SCP_I2C_DEV_RD)
              begin
                i2c_st_q <= IC_RDATA; // see RULE2
                i2c_rd_q <= 1'b1;
              end
              else
              begin
                // Foreign address: no acknowledge, idle until the next start
                i2c_st_q          <= IC_IDLE;
                i2c_ack_q         <= 1'b0;
                host_data_in_oe_o <= 1'b0;
              end
            end
            IC_ADDR:
            begin
              i2c_ld_q <= 1'b1; // see RULE3
              i2c_st_q <= IC_WDATA;
            end
            default:
              i2c_wr_q <= 1'b1; // see RULE3
          endcase
        end
        else if (i2c_st_q == IC_RDATA)
        begin
          if (i2c_cnt_q < 4'h8)
          begin
            host_data_in_oe_o <= ~tx_q[7];
            i2c_cnt_q         <= i2c_cnt_q + 4'h1;
          end
          else if (i2c_cnt_q == 4'h8)
          begin
            host_data_in_oe_o <= 1'b0;
            i2c_cnt_q         <= 4'h9;
          end
        end
      end
    end
  end

  // Open-drain data: the driven level is always low
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      host_data_in_o <= 1'b0;
    else
      host_data_in_o <= 1'b0;
  end

endmodule // scp_port

//--- scp_port_properties.sv
// Purpose: Port-level checks for the configuration slave port
// Assumes: Bound to scp_port from the bench top file
// Notes:   SPI side mainly; two-wire framing is left to the bench
`timescale 1ns/1ps
`include "scp_regs.vh"
module scp_port_properties #(
  parameter [7:0] REG_LAST = `SCP_REG_LAST
) (
  input wire       sys_clk_i,
  input wire       reset_i,
  input wire       host_select_n_i,
  input wire       host_serial_clock_i,
  input wire       host_data_in_oe_o,
  input wire       host_data_out_o,
  input wire [7:0] reg_addr_o,
  input wire       reg_wr_o,
  input wire       reg_rd_o,
  input wire       reg_window_o,
  input wire       spi_mode_o,
  input wire       i2c_mode_o
);
  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // Write strobe lasts one cycle and steps the counter next cycle
  wr_pulse_a: assert property (reg_wr_o |=> !reg_wr_o)
    else $error("write strobe longer than one cycle");
  wr_step_a: assert property (reg_wr_o && reg_addr_o < REG_LAST
    |=> reg_addr_o == $past(reg_addr_o) + 8'h01)
    else $error("address did not step after write");
  wr_wrap_a: assert property (reg_wr_o && reg_addr_o >= REG_LAST
    |=> reg_addr_o == 8'h00)
    else $error("address did not wrap to zero");
  // Read address must hold for eight cycles after the read strobe
  rd_hold_a: assert property (reg_rd_o |=> $stable(reg_addr_o) [*8])
    else $error("address moved while read byte in flight");
  // Window flag follows the address one cycle late
  window_flag_a: assert property (1'b1 |=> reg_window_o ==
    ($past(reg_addr_o) >= `SCP_WIN_FIRST &&
     $past(reg_addr_o) <= `SCP_WIN_LAST))
    else $error("window flag wrong for address");
  // Long serial clock high leaves no room for an output change
  miso_hold_a: assert property ((spi_mode_o && !host_select_n_i &&
    host_serial_clock_i) [*4] |-> $stable(host_data_out_o))
    else $error("serial output changed away from falling edge");
  // Once select is high the burst is dropped
  idle_quiet_a: assert property ((spi_mode_o && host_select_n_i) [*6]
    |-> !reg_wr_o && !reg_rd_o)
    else $error("register strobe with select high");
  mode_excl_a: assert property (!(spi_mode_o && i2c_mode_o))
    else $error("both slave modes active");
  i2c_quiet_a: assert property (spi_mode_o |-> !host_data_in_oe_o)
    else $error("two-wire data driven in SPI mode");
endmodule // scp_port_properties

//--- scp_host_model.sv
// Purpose: SPI and two-wire master model for the external controller
// Assumes: Serial clock stands still between frames, low after SPI and high after a two-wire stop
// Notes:   Output changes on falling edges, samples on rising edges
`timescale 1ns/1ps
module scp_host_model (
  output reg  sel_n_o,
  output reg  sck_o,
  output reg  mosi_o,
  input  wire miso_i,
  input  wire miso_oe_i,
  input  wire sda_i
);
  // Idle levels at time zero
  initial
  begin
    sel_n_o = 1'b1;
    sck_o   = 1'b0;
    mosi_o  = 1'b1;
  end

  // Select low, then a setup gap before the first bit
  task open_frame;
  begin
    sel_n_o = 1'b0;
    #40;
  end
  endtask

  // Released data line shows the inverse, never a stale value
  task close_frame;
  begin
    #40;
    sel_n_o = 1'b1;
    mosi_o  = ~mosi_o;
    #80;
  end
  endtask

  // Period 80 ns keeps the slave's oversampler in step
  task xfer(input [7:0] tx, input integer nb, output [7:0] rx);
    integer i;
  begin
    for (i = 7; i > 7 - nb; i = i - 1)
    begin
      mosi_o = tx[i];
      #40;
      sck_o  = 1'b1;
      rx[i]  = miso_oe_i ? miso_i : 1'bx;
      #40;
      sck_o  = 1'b0;
    end
  end
  endtask

  // Two-wire start, also a repeated start: data falls with clock high
  task i2c_start;
  begin
    mosi_o = 1'b1;
    #40;
    sck_o  = 1'b1;
    #40;
    mosi_o = 1'b0;
    #40;
    sck_o  = 1'b0;
  end
  endtask

  // Stop: data rises with clock high, then both lines rest high
  task i2c_stop;
  begin
    mosi_o = 1'b0;
    #40;
    sck_o  = 1'b1;
    #40;
    mosi_o = 1'b1;
    #80;
  end
  endtask

  // Nine clocks; a one in tx releases the line, rx holds the wire
  task i2c_byte(input [8:0] tx, output [8:0] rx);
    integer i;
  begin
    for (i = 8; i >= 0; i = i - 1)
    begin
      mosi_o = tx[i];
      #40;
      sck_o  = 1'b1;
      rx[i]  = sda_i;
      #40;
      sck_o  = 1'b0;
    end
  end
  endtask
endmodule // scp_host_model

//--- scp_port_tb_top.sv
// Purpose: Self-checking bench for the configuration slave port
// Assumes: Core answers reads combinationally from a flat array
// Notes:   Random data from a fixed xorshift seed
`timescale 1ns/1ps
`include "scp_regs.vh"
module scp_port_tb_top;
  localparam [7:0] REG_LAST = `SCP_REG_LAST;
  reg         sys_clk_i = 1'b0;
  reg         reset_i   = 1'b1;
  reg  [1:0]  straps    = `SCP_SEL_SPI;
  wire        sel_n, sck, mosi, miso, miso_oe, di_o, di_oe;
  wire        wr, rd, win, spi_m, i2c_m;
  wire [7:0]  addr, wdata;
  reg  [7:0]  mem [0:255];
  reg  [7:0]  exp_mem [0:255];
  reg  [31:0] seed = 32'd24116;
  reg         win_seen = 1'b0;
  reg  [7:0]  rx, a;
  reg  [8:0]  r9;
  integer     miscompares = 0, n_tests = 0, wr_cnt = 0, i, j, k;
  wire [7:0]  rdata = mem[addr];
  wire        din = mosi & ~di_oe;

  always #5 sys_clk_i = ~sys_clk_i;

  scp_host_model host (.sel_n_o(sel_n), .sck_o(sck), .mosi_o(mosi),
    .miso_i(miso), .miso_oe_i(miso_oe), .sda_i(din));

  scp_port #(.REG_LAST(REG_LAST)) dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .interface_select_straps_i(straps), .host_select_n_i(sel_n),
    .host_serial_clock_i(sck), .host_data_in_i(din),
    .host_data_in_o(di_o), .host_data_in_oe_o(di_oe),
    .host_data_out_o(miso), .host_data_out_oe_o(miso_oe),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_rdata_i(rdata), .reg_window_o(win),
    .spi_mode_o(spi_m), .i2c_mode_o(i2c_m));

  // Register core stand-in; counts writes for side-effect checks
  always @(posedge sys_clk_i)
  begin
    if (wr === 1'b1)
    begin
      mem[addr] <= wdata;
      wr_cnt    <= wr_cnt + 1;
    end
    if (win === 1'b1)
      win_seen <= 1'b1;
  end

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function [7:0] rnd();
  begin
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd  = seed[7:0];
  end
  endfunction

  function [7:0] nxt(input [7:0] v);
    nxt = (v == REG_LAST) ? 8'h00 : v + 8'h01;
  endfunction

  task chk(input [31:0] got, input [31:0] want, input string what);
  begin
    n_tests = n_tests + 1;
    if (got !== want)
    begin
      miscompares = miscompares + 1;
      $display("Error at %0t: %s got %h want %h", $time, what, got, want);
    end
  end
  endtask

  task spi_wr(input [7:0] s, input integer n);
    reg [7:0] p, d;
    integer   m;
  begin
    p = s;
    host.open_frame;
    host.xfer(`SCP_SPI_CMD_WR, 8, rx);
    host.xfer(s, 8, rx);
    for (m = 0; m < n; m = m + 1)
    begin
      d = rnd();
      exp_mem[p] = d;
      host.xfer(d, 8, rx);
      p = nxt(p);
    end
    host.close_frame;
  end
  endtask

  task spi_rd(input [7:0] s, input integer n);
    reg [7:0] p;
    integer   m;
  begin
    p = s;
    host.open_frame;
    host.xfer(`SCP_SPI_CMD_RD, 8, rx);
    host.xfer(s, 8, rx);
    for (m = 0; m < n; m = m + 1)
    begin
      host.xfer(rnd(), 8, rx);
      chk(rx, exp_mem[p], "read data");
      p = nxt(p);
    end
    host.close_frame;
  end
  endtask

  task end_sim;
  begin
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  initial
  begin
    for (i = 0; i < 256; i = i + 1)
    begin
      mem[i]     = 8'h00;
      exp_mem[i] = 8'h00;
    end
    repeat (10) @(posedge sys_clk_i);
    #1 reset_i = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    #1 chk({i2c_m, spi_m}, 2'h1, "mode flags");
    // Burst across the top of the map, then read back
    spi_wr(REG_LAST - 8'h01, 4);
    spi_rd(REG_LAST - 8'h01, 4);
    $display("Test wrap done at %0t", $time);
    for (j = 0; j < 4; j = j + 1)
    begin
      a = rnd() % (REG_LAST + 8'h01);
      k = 1 + rnd() % 8'h03;
      spi_wr(a, k);
      spi_rd(a, k);
    end
    $display("Test random done at %0t", $time);
    // Park the address outside the window before watching the flag
    spi_wr(8'h10, 2);
    win_seen = 1'b0;
    spi_wr(8'h10, 2);
    chk(win_seen, 1'b0, "window outside");
    win_seen = 1'b0;
    spi_wr(`SCP_WIN_LAST - 8'h01, 3);
    chk(win_seen, 1'b1, "window inside");
    $display("Test window done at %0t", $time);
    // Target holds data, so a misread command would show it
    spi_wr(8'h20, 1);
    // Each bad command is one bit away from the read command
    for (j = 0; j < 5; j = j + 1)
    begin
      k = wr_cnt;
      host.open_frame;
      host.xfer(8'h03 ^ (8'h20 >> j), 8, rx);
      host.xfer(8'h20, 8, rx);
      host.xfer(rnd(), 8, rx);
      host.close_frame;
      chk(rx, 8'h00, "output on bad command");
      chk(wr_cnt - k, 0, "write on bad command");
    end
    $display("Test command done at %0t", $time);
    // Select high in mid-byte drops the partial byte
    k = wr_cnt;
    host.open_frame;
    host.xfer(`SCP_SPI_CMD_WR, 8, rx);
    host.xfer(8'h40, 8, rx);
    exp_mem[8'h40] = rnd();
    host.xfer(exp_mem[8'h40], 8, rx);
    host.xfer(rnd(), 4, rx);
    host.close_frame;
    chk(wr_cnt - k, 1, "writes in aborted burst");
    spi_rd(8'h40, 2);
    $display("Test abort done at %0t", $time);
    // Second reset with the two-wire strap
    @(posedge sys_clk_i);
    #1 reset_i = 1'b1;
    straps = `SCP_SEL_I2C;
    repeat (3) @(posedge sys_clk_i);
    #1 reset_i = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    #1 chk({di_o, miso_oe, i2c_m, spi_m}, 4'h2, "i2c flags");
    $display("Test strap done at %0t", $time);
    // Two-wire: write two registers, then random read them back
    a = rnd() % REG_LAST;
    exp_mem[a] = rnd();
    exp_mem[nxt(a)] = rnd();
    host.i2c_start;
    host.i2c_byte({`SCP_I2C_DEV_WR, 1'b1}, r9);
    chk(r9[0], 1'b0, "write address ack");
    host.i2c_byte({a, 1'b1}, r9);
    host.i2c_byte({exp_mem[a], 1'b1}, r9);
    host.i2c_byte({exp_mem[nxt(a)], 1'b1}, r9);
    host.i2c_start;
    host.i2c_byte({`SCP_I2C_DEV_WR, 1'b1}, r9);
    host.i2c_byte({a, 1'b1}, r9);
    host.i2c_start;
    host.i2c_byte({`SCP_I2C_DEV_RD, 1'b1}, r9);
    chk(r9[0], 1'b0, "read address ack");
    host.i2c_byte(9'h1fe, r9);
    chk(r9[8:1], exp_mem[a], "two-wire read");
    host.i2c_byte(9'h1ff, r9);
    chk(r9[8:1], exp_mem[nxt(a)], "two-wire burst read");
    host.i2c_stop;
    // A foreign address byte gets no acknowledge
    host.i2c_start;
    host.i2c_byte({8'hbc, 1'b1}, r9);
    chk(r9[0], 1'b1, "foreign address ack");
    host.i2c_stop;
    $display("Test two-wire done at %0t", $time);
    end_sim;
  end

  // Whole run needs well under 100 us of link traffic
  initial
  begin
    #500000;
    miscompares = miscompares + 1;
    $display("Error at %0t: watchdog expired", $time);
    end_sim;
  end
endmodule // scp_port_tb_top

bind scp_port scp_port_properties #(.REG_LAST(REG_LAST)) u_props (.*);
